// ===== shared/dpsss_pkg.sv
package dpsss_pkg;

	// register byte offsets
	localparam logic [7:0] CTRL_OFF      = 8'h00;
	localparam logic [7:0] STATUS_OFF    = 8'h04;
	localparam logic [7:0] IRQ_STAT_OFF  = 8'h08;
	localparam logic [7:0] IRQ_MASK_OFF  = 8'h0c;
	localparam logic [7:0] HB_TMO_OFF    = 8'h10;
	localparam logic [7:0] HB_SEND_OFF   = 8'h14;

	// ctrl fields
	localparam int CTRL_FORCE_BIT = 0;
	localparam int CTRL_HB_EN_BIT = 1;
	localparam int CTRL_OVP_BIT   = 2;

	// irq status / mask fields
	localparam int IRQ_HB_LOST_BIT  = 0;
	localparam int IRQ_SAFE_ENT_BIT = 1;
	localparam int IRQ_SAFE_EXT_BIT = 2;
	localparam int IRQ_OVP_BIT      = 3;
	localparam int IRQ_WIDTH        = 4;

	// reset values
	localparam logic [31:0] CTRL_RST     = 32'h0000_0000;
	localparam logic [31:0] IRQ_MASK_RST = 32'h0000_0000;
	localparam logic [31:0] HB_TMO_RST   = 32'h0098_9680;

	// timing
	localparam longint CLK_HZ          = 200_000_000;
	localparam longint SAFE_MAX_MIN    = 10;
	localparam longint SAFE_MAX_CYCLES = SAFE_MAX_MIN * 64'd60 * CLK_HZ;

	localparam logic [1:0] RESP_OKAY   = 2'b00;
	localparam logic [1:0] RESP_SLVERR = 2'b10;

	typedef enum {
		DPSSS_NORMAL,
		DPSSS_SAFE
	} dpsss_state_e;

	typedef struct packed {
		logic pump_on;
		logic deflate_open;
		logic dump_open;
	} dpsss_manifold_s;

	typedef struct packed {
		logic patient_parameter_interface_en;
		logic alarm_tone;
		logic comms_enable;
		logic remote_alarm;
		logic primary_reset_n;
	} dpsss_outputs_s;

endpackage

// ===== rtl/dpsss_supervisor.sv
`timescale 1ns/1ps
`default_nettype none
module dpsss_supervisor
	import dpsss_pkg::*;
#(
	parameter int     KEY_W        = 16,
	parameter int     PWR_KEY_IDX  = 0,
	parameter longint SAFE_CYCLES  = SAFE_MAX_CYCLES,
	parameter int     RST_PULSE    = 16
) (
	input  wire logic                     aclk,
	input  wire logic                     aresetn,
	input  wire logic                     clk_en,
	input  wire logic [7:0]               s_axi_awaddr,
	input  wire logic                     s_axi_awvalid,
	output logic                          s_axi_awready,
	input  wire logic [31:0]              s_axi_wdata,
	input  wire logic [3:0]               s_axi_wstrb,
	input  wire logic                     s_axi_wvalid,
	output logic                          s_axi_wready,
	output logic [1:0]                    s_axi_bresp,
	output logic                          s_axi_bvalid,
	input  wire logic                     s_axi_bready,
	input  wire logic [7:0]               s_axi_araddr,
	input  wire logic                     s_axi_arvalid,
	output logic                          s_axi_arready,
	output logic [31:0]                   s_axi_rdata,
	output logic [1:0]                    s_axi_rresp,
	output logic                          s_axi_rvalid,
	input  wire logic                     s_axi_rready,
	input  wire logic                     hb_rx,
	output logic                          hb_tx,
	input  wire logic                     peer_failsafe,
	output logic                          failsafe_out,
	input  wire logic                     overpressure_in,
	input  wire logic                     primary_pump_on,
	input  wire logic                     primary_deflate_open,
	input  wire logic                     primary_dump_open,
	output dpsss_manifold_s               valve_manifold,
	output logic                          overpressure_out,
	input  wire logic                     patient_parameter_interface_req,
	input  wire logic                     comms_enable_req,
	input  wire logic                     remote_alarm_req,
	input  wire logic [KEY_W-1:0]         keys_in,
	output logic [KEY_W-1:0]              keys_out,
	output dpsss_outputs_s                sys_out,
	output logic                          irq
);
	import dpsss_pkg::*;

	// software-visible registers and internal state; status is built from live state on read
	// so it never goes stale against the safe state machine
	logic [31:0]       ctrl_reg;
	logic [31:0]       hb_tmo_reg;
	logic [IRQ_WIDTH-1:0] irq_stat_reg;
	logic [IRQ_WIDTH-1:0] irq_mask_reg;
	logic [31:0]       hb_cnt_reg;
	logic [63:0]       safe_cnt_reg;
	logic [7:0]        rst_cnt_reg;
	dpsss_state_e      state_reg;
	logic              pwr_key_d_reg;
	logic              ovp_d_reg;
	logic              hb_lost_reg;

	// write address and data are latched separately so the master may
	// present them in either order; the response waits for both
	logic              aw_hold_reg;
	logic              w_hold_reg;
	logic [7:0]        awaddr_reg;
	logic [31:0]       wdata_reg;
	logic [3:0]        wstrb_reg;

	logic              wr_go;
	logic              rd_go;
	logic              pwr_press;
	logic              force_safe;
	logic              safe_expired;
	logic              enter_safe;
	logic              exit_safe;
	logic              hb_lost_now;
	logic              ovp_rise;
	logic              stat_read;
	logic [IRQ_WIDTH-1:0] irq_events;

	function automatic logic [31:0] merge_strb(input logic [31:0] old_v,
		input logic [31:0] new_v, input logic [3:0] strb);
		logic [31:0] r;
		r = old_v;
		for (int i = 0; i < 4; i++) begin
			if (strb[i]) begin
				r[i*8 +: 8] = new_v[i*8 +: 8];
			end
		end
		return r;
	endfunction

	// write channel: address and data taken independently, in either order
	assign wr_go = aw_hold_reg && w_hold_reg && !s_axi_bvalid;
	assign rd_go = s_axi_arvalid && s_axi_arready;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_hold_reg   <= 1'b0;
			w_hold_reg    <= 1'b0;
			awaddr_reg    <= 8'h00;
			wdata_reg     <= 32'h0000_0000;
			wstrb_reg     <= 4'h0;
			s_axi_awready <= 1'b0;
			s_axi_wready  <= 1'b0;
			s_axi_bvalid  <= 1'b0;
			s_axi_bresp   <= RESP_OKAY;
		end else if (clk_en) begin
			s_axi_awready <= !aw_hold_reg && !s_axi_awready;
			s_axi_wready  <= !w_hold_reg && !s_axi_wready;
			if (s_axi_awvalid && s_axi_awready) begin
				aw_hold_reg   <= 1'b1;
				awaddr_reg    <= s_axi_awaddr;
				s_axi_awready <= 1'b0;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_hold_reg   <= 1'b1;
				wdata_reg    <= s_axi_wdata;
				wstrb_reg    <= s_axi_wstrb;
				s_axi_wready <= 1'b0;
			end
			if (wr_go) begin
				aw_hold_reg  <= 1'b0;
				w_hold_reg   <= 1'b0;
				s_axi_bvalid <= 1'b1;
				case (awaddr_reg)
					CTRL_OFF, IRQ_MASK_OFF, HB_TMO_OFF, HB_SEND_OFF,
					IRQ_STAT_OFF, STATUS_OFF: s_axi_bresp <= RESP_OKAY;
					default: s_axi_bresp <= RESP_SLVERR;
				endcase
			end else if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	// writable registers
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ctrl_reg     <= CTRL_RST;
			irq_mask_reg <= IRQ_MASK_RST[IRQ_WIDTH-1:0];
			hb_tmo_reg   <= HB_TMO_RST;
		end else if (clk_en) begin
			if (wr_go) begin
				case (awaddr_reg)
					CTRL_OFF: ctrl_reg <= merge_strb(ctrl_reg, wdata_reg, wstrb_reg);
					IRQ_MASK_OFF: begin
						// only the low bits exist; upper write data is dropped
						irq_mask_reg <= IRQ_WIDTH'(merge_strb({28'h0, irq_mask_reg},
							wdata_reg, wstrb_reg));
					end
					HB_TMO_OFF: hb_tmo_reg <= merge_strb(hb_tmo_reg, wdata_reg, wstrb_reg);
					default: ;
				endcase
			end
			// any exit from the safe state, by key or by timeout, also drops a software force request
			if (exit_safe) begin
				ctrl_reg[CTRL_FORCE_BIT] <= 1'b0;
			end
		end
	end

	// heartbeat out: one pulse per software write, only while enabled
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			hb_tx <= 1'b0;
		end else if (clk_en) begin
			hb_tx <= wr_go && (awaddr_reg == HB_SEND_OFF) && wstrb_reg[0]
				&& wdata_reg[0] && ctrl_reg[CTRL_HB_EN_BIT];
		end
	end

	// peer liveness window, restarted by each heartbeat
	// the counter stops at the limit instead of wrapping, so a silent peer
	// stays reported lost until it speaks again, heartbeats are disabled or the safe state ends
	// the window is off while heartbeats are disabled, so a fresh boot
	// cannot trip before software has set a sensible timeout
	assign hb_lost_now = ctrl_reg[CTRL_HB_EN_BIT] && !hb_rx
		&& (hb_cnt_reg >= hb_tmo_reg);

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			hb_cnt_reg  <= 32'h0000_0000;
			hb_lost_reg <= 1'b0;
		end else if (clk_en) begin
			if (hb_rx || !ctrl_reg[CTRL_HB_EN_BIT] || exit_safe) begin
				hb_cnt_reg  <= 32'h0000_0000;
				hb_lost_reg <= 1'b0;
			end else if (hb_lost_now) begin
				hb_lost_reg <= 1'b1;
			end else begin
				hb_cnt_reg <= hb_cnt_reg + 32'h0000_0001;
			end
		end
	end

	assign pwr_press    = keys_in[PWR_KEY_IDX] && !pwr_key_d_reg;
	assign force_safe   = ctrl_reg[CTRL_FORCE_BIT] || peer_failsafe || hb_lost_reg;
	assign safe_expired = safe_cnt_reg >= SAFE_CYCLES - 64'd1;
	assign exit_safe    = (state_reg == DPSSS_SAFE) && (pwr_press || safe_expired);
	// any single source is enough; no agreement between the sides is needed
	assign enter_safe   = (state_reg == DPSSS_NORMAL) && force_safe;

	// safe state machine; runs independent of the primary power state
	// a force source still high after an exit re-enters on the next cycle;
	// this is deliberate, a live fault must not be cleared by a key press
	// the power key is edge detected, so a held key cannot leave and
	// re-enter repeatedly; its delay flop resets low like the idle key
	// the timeout counter is wide enough for the full ten minute span
	// at the nominal clock, so it cannot wrap before it expires
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			state_reg     <= DPSSS_NORMAL;
			safe_cnt_reg  <= 64'd0;
			pwr_key_d_reg <= 1'b0;
		end else if (clk_en) begin
			pwr_key_d_reg <= keys_in[PWR_KEY_IDX];
			case (state_reg)
				DPSSS_NORMAL: begin
					safe_cnt_reg <= 64'd0;
					if (enter_safe) begin
						state_reg <= DPSSS_SAFE;
					end
				end
				DPSSS_SAFE: begin
					safe_cnt_reg <= safe_cnt_reg + 64'd1;
					if (pwr_press) begin
						state_reg <= DPSSS_NORMAL;
					end else if (safe_expired) begin
						state_reg <= DPSSS_NORMAL;
					end
				end
				default: state_reg <= DPSSS_NORMAL;
			endcase
		end
	end

	// primary reset pulse on power key exit
	// a timeout exit leaves the primary running: only the key resets it
	// the pulse length is fixed by parameter and must fit eight bits
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rst_cnt_reg <= 8'h00;
		end else if (clk_en) begin
			if (exit_safe && pwr_press) begin
				rst_cnt_reg <= 8'(RST_PULSE);
			end else if (rst_cnt_reg != 8'h00) begin
				rst_cnt_reg <= rst_cnt_reg - 8'h01;
			end
		end
	end

	// outputs; force is so a glitch-free registered path controls the pneumatics
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			valve_manifold   <= '{pump_on: 1'b0, deflate_open: 1'b1, dump_open: 1'b1};
			overpressure_out <= 1'b0;
			failsafe_out     <= 1'b0;
			keys_out         <= '0;
			sys_out          <= '{patient_parameter_interface_en: 1'b0, alarm_tone: 1'b0,
				comms_enable: 1'b0, remote_alarm: 1'b0, primary_reset_n: 1'b0};
			ovp_d_reg        <= 1'b0;
		end else if (clk_en) begin
			ovp_d_reg        <= overpressure_in;
			overpressure_out <= overpressure_in || ctrl_reg[CTRL_OVP_BIT];
			failsafe_out     <= state_reg == DPSSS_SAFE;
			if (state_reg == DPSSS_SAFE || overpressure_in || ctrl_reg[CTRL_OVP_BIT]) begin
				valve_manifold <= '{pump_on: 1'b0, deflate_open: 1'b1,
					dump_open: 1'b1};
			end else begin
				valve_manifold <= '{pump_on: primary_pump_on,
					deflate_open: primary_deflate_open,
					dump_open: primary_dump_open};
			end
			if (state_reg == DPSSS_SAFE) begin
				sys_out.patient_parameter_interface_en <= 1'b0;
				sys_out.alarm_tone   <= 1'b1;
				sys_out.comms_enable <= 1'b0;
				sys_out.remote_alarm <= 1'b0;
				keys_out             <= keys_in & (KEY_W'(1) << PWR_KEY_IDX);
			end else begin
				sys_out.patient_parameter_interface_en <= patient_parameter_interface_req;
				sys_out.alarm_tone   <= 1'b0;
				sys_out.comms_enable <= comms_enable_req;
				sys_out.remote_alarm <= remote_alarm_req;
				keys_out             <= keys_in;
			end
			sys_out.primary_reset_n <= (rst_cnt_reg == 8'h00) && !(exit_safe && pwr_press);
		end
	end

	// sticky interrupt status, cleared on read, set wins
	// an event in the cycle of the clearing read is kept for the next read
	// rather than lost; irq is derived from the next status value so it
	// follows the register without an extra cycle of lag
	assign ovp_rise   = overpressure_in && !ovp_d_reg;
	assign stat_read  = rd_go && (s_axi_araddr == IRQ_STAT_OFF);
	always_comb begin
		irq_events = '0;
		irq_events[IRQ_HB_LOST_BIT]  = hb_lost_now && !hb_lost_reg;
		irq_events[IRQ_SAFE_ENT_BIT] = enter_safe;
		irq_events[IRQ_SAFE_EXT_BIT] = exit_safe;
		irq_events[IRQ_OVP_BIT]      = ovp_rise;
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			irq_stat_reg <= '0;
			irq          <= 1'b0;
		end else if (clk_en) begin
			irq_stat_reg <= (stat_read ? '0 : irq_stat_reg) | irq_events;
			irq          <= |(((stat_read ? '0 : irq_stat_reg) | irq_events) & irq_mask_reg);
		end
	end

	// read channel: arready one cycle, data the next
	// the address is used live at the handshake edge, so the master
	// must hold it until arready is seen, as the bus requires
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= 32'h0000_0000;
			s_axi_rresp   <= RESP_OKAY;
		end else if (clk_en) begin
			s_axi_arready <= !s_axi_rvalid && !s_axi_arready && s_axi_arvalid;
			if (rd_go) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rresp  <= RESP_OKAY;
				case (s_axi_araddr)
					CTRL_OFF:     s_axi_rdata <= ctrl_reg;
					STATUS_OFF:   s_axi_rdata <= {28'h0, hb_lost_reg, overpressure_in,
						peer_failsafe, state_reg == DPSSS_SAFE};
					IRQ_STAT_OFF: s_axi_rdata <= {28'h0, irq_stat_reg};
					IRQ_MASK_OFF: s_axi_rdata <= {28'h0, irq_mask_reg};
					HB_TMO_OFF:   s_axi_rdata <= hb_tmo_reg;
					HB_SEND_OFF:  s_axi_rdata <= 32'h0000_0000;
					default: begin
						s_axi_rdata <= 32'h0000_0000;
						s_axi_rresp <= RESP_SLVERR;
					end
				endcase
			end else if (s_axi_rvalid && s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
		end
	end

endmodule
`default_nettype wire

// ===== verif/dpsss_sva.sv
`timescale 1ns/1ps
`default_nettype none
module dpsss_sva
	import dpsss_pkg::*;
#(
	parameter int     KEY_W       = 16,
	parameter int     PWR_KEY_IDX = 0,
	parameter longint SAFE_CYCLES = 200
) (
	input wire logic                      aclk,
	input wire logic                      aresetn,
	input wire logic                      hb_tx,
	input wire logic                      peer_failsafe,
	input wire logic                      failsafe_out,
	input wire logic                      overpressure_in,
	input wire logic                      primary_pump_on,
	input wire logic                      primary_deflate_open,
	input wire logic                      primary_dump_open,
	input wire dpsss_pkg::dpsss_manifold_s valve_manifold,
	input wire logic                      overpressure_out,
	input wire logic [KEY_W-1:0]          keys_in,
	input wire logic [KEY_W-1:0]          keys_out,
	input wire dpsss_pkg::dpsss_outputs_s sys_out
);
	longint fs_cnt;
	// counts how long the safe state has stood
	always_ff @(posedge aclk) begin
		if (!aresetn || !failsafe_out)
			fs_cnt <= 0;
		else
			fs_cnt <= fs_cnt + 1;
	end
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	sequence s_pwr_press;
		failsafe_out && !peer_failsafe && $rose(keys_in[PWR_KEY_IDX]);
	endsequence
	sequence s_released;
		##[1:3] !failsafe_out;
	endsequence
	a_safe_outputs: assert property (failsafe_out |-> sys_out.alarm_tone
		&& !sys_out.patient_parameter_interface_en
		&& !sys_out.comms_enable && !sys_out.remote_alarm) else $error("safe outputs wrong");
	a_safe_keys: assert property (failsafe_out |->
		(keys_out & ~(KEY_W'(1) << PWR_KEY_IDX)) == '0) else $error("keys pass in safe");
	a_safe_vent: assert property (failsafe_out |->
		!valve_manifold.pump_on && valve_manifold.deflate_open) else $error("no vent in safe");
	a_normal_manifold: assert property (!failsafe_out && !overpressure_out && $past(aresetn) |->
		valve_manifold == {$past(primary_pump_on), $past(primary_deflate_open),
		$past(primary_dump_open)}) else $error("manifold not from primary");
	a_ovp_vent: assert property (overpressure_in |=>
		!valve_manifold.pump_on && valve_manifold.deflate_open) else $error("no vent on overpressure");
	a_ovp_out: assert property (overpressure_in |=> overpressure_out)
		else $error("overpressure not passed");
	a_peer_force: assert property (peer_failsafe |-> ##[1:3] failsafe_out)
		else $error("peer force ignored");
	a_pwr_exit: assert property (s_pwr_press |-> s_released)
		else $error("power key did not end safe");
	a_safe_timeout: assert property (fs_cnt <= SAFE_CYCLES + 2)
		else $error("safe state too long");
	a_hb_pulse: assert property (hb_tx |=> !hb_tx)
		else $error("heartbeat not a pulse");
	a_keys_normal: assert property (!failsafe_out && $past(aresetn) |-> keys_out == $past(keys_in))
		else $error("keys blocked in normal");
endmodule
bind dpsss_supervisor dpsss_sva #(
	.KEY_W(KEY_W),
	.PWR_KEY_IDX(PWR_KEY_IDX),
	.SAFE_CYCLES(SAFE_CYCLES)
) dpsss_sva_inst (
	.aclk(aclk),
	.aresetn(aresetn),
	.hb_tx(hb_tx),
	.peer_failsafe(peer_failsafe),
	.failsafe_out(failsafe_out),
	.overpressure_in(overpressure_in),
	.primary_pump_on(primary_pump_on),
	.primary_deflate_open(primary_deflate_open),
	.primary_dump_open(primary_dump_open),
	.valve_manifold(valve_manifold),
	.overpressure_out(overpressure_out),
	.keys_in(keys_in),
	.keys_out(keys_out),
	.sys_out(sys_out)
);
`default_nettype wire

// ===== verif/dpsss_peer.sv
`timescale 1ns/1ps
`default_nettype none
module dpsss_peer #(
	parameter int PERIOD = 10
) (
	input  wire logic aclk,
	input  wire logic aresetn,
	input  wire logic alive,
	input  wire logic fail_cmd,
	output logic      hb,
	output logic      failsafe
);
	int cnt;
	// a halted peer simply goes quiet
	always_ff @(posedge aclk) begin
		hb <= 1'b0;
		if (!aresetn) begin
			cnt <= 0;
		end else if (alive) begin
			cnt <= (cnt == PERIOD - 1) ? 0 : cnt + 1;
			hb <= (cnt == PERIOD - 1);
		end
	end
	always_ff @(posedge aclk) begin
		failsafe <= aresetn && fail_cmd;
	end
endmodule
`default_nettype wire

// ===== verif/dpsss_supervisor_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module dpsss_supervisor_tb_top;
	import dpsss_pkg::*;
	typedef struct packed {logic [31:0] d; logic [1:0] r;} dpsss_exp_s;
	localparam longint SAFE_SIM = 200;
	logic aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
	logic [7:0] awaddr = 0, araddr = 0;
	logic [31:0] wdata = 0, rdata;
	logic [3:0] wstrb = 0;
	logic [1:0] bresp, rresp;
	logic awready, wready, bvalid, arready, rvalid, hb_rx, hb_tx, peer_fs, fs_out, ovp_out, irq;
	logic ovp_in = 0, alive = 0, fail_cmd = 0, pwr_key = 0;
	logic [5:0] prim = 0;
	logic [14:0] key_rnd = 0;
	logic [15:0] keys_out;
	dpsss_manifold_s vm;
	dpsss_outputs_s so;
	int failures = 0, tests_run = 0, seed = 32'hd2ec, hb_cnt = 0;
	dpsss_exp_s q[$], e;
	always #2.5 aclk = ~aclk;
	dpsss_peer dpsss_peer_inst (.aclk(aclk), .aresetn(aresetn), .alive(alive),
		.fail_cmd(fail_cmd), .hb(hb_rx), .failsafe(peer_fs));
	dpsss_supervisor #(.SAFE_CYCLES(SAFE_SIM)) dpsss_supervisor_inst (.aclk(aclk),
		.aresetn(aresetn), .clk_en(1'b1), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
		.s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
		.s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
		.hb_rx(hb_rx), .hb_tx(hb_tx), .peer_failsafe(peer_fs), .failsafe_out(fs_out),
		.overpressure_in(ovp_in), .primary_pump_on(prim[0]), .primary_deflate_open(prim[1]),
		.primary_dump_open(prim[2]), .valve_manifold(vm), .overpressure_out(ovp_out),
		.patient_parameter_interface_req(prim[3]), .comms_enable_req(prim[4]),
		.remote_alarm_req(prim[5]),
		.keys_in({key_rnd, pwr_key}), .keys_out(keys_out), .sys_out(so), .irq(irq));
	always @(posedge aclk) begin
		prim <= 6'($random(seed));
		key_rnd <= 15'($random(seed));
		if (hb_tx === 1'b1)
			hb_cnt <= hb_cnt + 1;
	end
	task chk(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			failures++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	always @(posedge aclk) begin
		if (rvalid && rready) begin
			e = q.pop_front();
			chk(rdata, e.d);
			chk({30'h0, rresp}, {30'h0, e.r});
		end
	end
	task wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge aclk);
		awaddr <= a; awvalid <= 1; wdata <= d; wstrb <= 4'hf; wvalid <= 1;
		fork
			begin do @(posedge aclk); while (awready !== 1'b1); awvalid <= 0; end
			begin do @(posedge aclk); while (wready !== 1'b1); wvalid <= 0; end
		join
		bready <= 1;
		do @(posedge aclk); while (bvalid !== 1'b1);
		bready <= 0;
		chk({30'h0, bresp}, {30'h0, RESP_OKAY});
	endtask
	task rd(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
		@(posedge aclk);
		araddr <= a; arvalid <= 1;
		q.push_back({d, r});
		do @(posedge aclk); while (arready !== 1'b1);
		arvalid <= 0; rready <= 1;
		do @(posedge aclk); while (rvalid !== 1'b1);
		rready <= 0;
	endtask
	task wait_fs(input logic v);
		for (int n = 0; n < 400 && fs_out !== v; n++) @(posedge aclk);
		chk({31'h0, fs_out}, {31'h0, v});
	endtask
	task key_press;
		@(posedge aclk);
		pwr_key <= 1;
		repeat (3) @(posedge aclk);
		pwr_key <= 0;
	endtask
	task print_verdict;
		$display("tests_run=%0d failures=%0d", tests_run, failures);
		if (failures == 0 && tests_run > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	// whole run is a few hundred cycles; allow ample margin
	initial begin
		#(20000 * 5);
		failures++;
		print_verdict();
	end
	initial begin
		repeat (3) @(posedge aclk);
		aresetn <= 1;
		rd(CTRL_OFF, CTRL_RST, RESP_OKAY);
		rd(IRQ_MASK_OFF, IRQ_MASK_RST, RESP_OKAY);
		rd(HB_TMO_OFF, HB_TMO_RST, RESP_OKAY);
		rd(8'h40, 32'h0, RESP_SLVERR);
		rd(HB_SEND_OFF, 32'h0, RESP_OKAY);
		wr(IRQ_MASK_OFF, 32'h2);
		$display("registers done");
		alive <= 1;
		wr(HB_TMO_OFF, 32'd20);
		wr(CTRL_OFF, 32'h2);
		repeat (100) @(posedge aclk);
		rd(STATUS_OFF, 32'h0, RESP_OKAY);
		wr(HB_SEND_OFF, 32'h1);
		repeat (3) @(posedge aclk);
		chk(hb_cnt, 1);
		alive <= 0;
		wait_fs(1);
		rd(STATUS_OFF, 32'h9, RESP_OKAY);
		chk({31'h0, irq}, 32'h1);
		rd(IRQ_STAT_OFF, 32'h3, RESP_OKAY);
		repeat (3) @(posedge aclk);
		chk({31'h0, irq}, 32'h0);
		alive <= 1;
		wr(CTRL_OFF, 32'h0);
		key_press();
		wait_fs(0);
		chk({31'h0, so.primary_reset_n}, 32'h0);
		$display("heartbeat done");
		wr(CTRL_OFF, 32'h1);
		wait_fs(1);
		chk({31'h0, so.alarm_tone}, 32'h1);
		chk({31'h0, vm.pump_on}, 32'h0);
		chk({31'h0, so.patient_parameter_interface_en}, 32'h0);
		repeat (SAFE_SIM - 20) @(posedge aclk);
		chk({31'h0, fs_out}, 32'h1);
		wait_fs(0);
		$display("timeout done");
		fail_cmd <= 1;
		wait_fs(1);
		rd(STATUS_OFF, 32'h3, RESP_OKAY);
		fail_cmd <= 0;
		key_press();
		wait_fs(0);
		ovp_in <= 1;
		repeat (3) @(posedge aclk);
		chk({31'h0, ovp_out}, 32'h1);
		chk({31'h0, vm.deflate_open}, 32'h1);
		ovp_in <= 0;
		$display("peer and overpressure done");
		print_verdict();
	end
endmodule
`default_nettype wire
